// *** pkg/ldm_pkg.sv ***
/*
  Constants, field layouts, register map, states and carrier types of the
  serial dot matrix loader.
  Assumes one system clock mclk at 250 MHz and a host serial clock that
  may pulse outside chip-enable frames, where its edges change nothing.
*/
// Function
// [RULE1] Reset low-active pin clears all control bits; dot data stays unchanged. Here rst is high-active.
// [RULE2] Rising serial clock with chip enable low shifts data in into target.
// [RULE3] Serial data out presents dot or control data for the next display.
// [RULE4] Target select level is caught when chip enable falls.
// [RULE5] Host holds chip enable low through a write, else nothing loads.
// [RULE6] Chip enable high with clock low copies shift data to its destination.
// [RULE7] Oscillator select low means external, high means internal display clock.
// [RULE8] Oscillator pin drives internal clock out, or takes external clock in.
// [RULE9] Blank high turns all LEDs off; host may pulse it for brightness.
// [RULE10] Holds a 160-bit dot shift register, two 7-bit words, refresh logic.
// [RULE11] Each dot bit drives exactly one LED.
// [RULE12] Data out feeds a second chip, forming one 320-bit dot chain.
// [RULE13] Reset puts the display in sleep, so the LEDs are dark.
// [RULE14] Neither power-up nor reset clears the dot register.
// [RULE15] After reset host loads zeros, then word 0 with sleep bit high.
// [RULE16] Control write is eight bits MSB first; top bit picks the word.
// [RULE17] Sleep bit low stops internal oscillator and drivers, keeps data.
// [RULE18] Control write: select high, enable low, eight clocks, enable high.
// [RULE19] Serial clock edges with chip enable high change nothing.
package ldm_pkg;
  localparam int DOT_BITS = 160;
  localparam int CW_BITS = 7;
  localparam int CSR_BITS = 8;
  localparam int CW_SEL_BIT = 7;
  localparam int SLEEP_BIT = 6;
  localparam int SIMUL_BIT = 0;
  localparam int PRESCALE_BIT = 1;
  localparam int PRESCALE_DIV = 8;
  localparam int REFRESH_BITS = 9;
  localparam logic [CW_BITS-1:0] CW_RESET = 7'h00;
  localparam logic TARGET_DOT = 1'b0;
  localparam logic TARGET_CTRL = 1'b1;

  // Timing: system clock and internal display oscillator
  localparam int CLK_KHZ = 250000;
  localparam int INT_OSC_KHZ = 210;
  localparam int INT_OSC_HALF = CLK_KHZ / (2 * INT_OSC_KHZ);
  localparam int OSC_CNT_BITS = 12;

  // Wishbone register map, byte addresses
  localparam int ADR_BITS = 8;
  localparam logic [ADR_BITS-1:0] ADR_STATUS = 8'h00;
  localparam logic [ADR_BITS-1:0] ADR_DOT_INDEX = 8'h04;
  localparam logic [ADR_BITS-1:0] ADR_DOT_DATA = 8'h08;
  localparam int DOT_WORDS = 5;
  localparam int IDX_BITS = 3;

  // Status register fields
  localparam int ST_CW0_LSB = 0;
  localparam int ST_CW1_LSB = 8;
  localparam int ST_TARGET_BIT = 16;
  localparam int ST_OSCSEL_BIT = 17;
  localparam int ST_BLANK_BIT = 18;
  localparam int ST_AWAKE_BIT = 19;

  typedef struct packed {
    logic ceN;
    logic sclk;
    logic target;
    logic blank;
    logic oscSel;
    logic oscIn;
  } ldm_pins_t;

  localparam int PIN_BITS = 6;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_WAIT_LOW = 1'b1
  } ldm_copy_t;
endpackage

// *** verilog/ldm_sync.sv ***
/*
  Two-stage synchroniser for a group of pin levels.
  Assumes the inputs are levels from outside the mclk domain.
*/
`timescale 1ns/10ps
module ldm_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Levels
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stage1 <= INIT;
      dout <= INIT;
    end
    else
    begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule

// *** verilog/ldm_core.sv ***
/*
  Serial write front end of a four-character dot matrix driver: dot and
  control shift registers on the host serial clock, dot latch, control
  words, display clock selection, blanking and a Wishbone status port.
  Assumes the host keeps chip enable and target select steady per frame
  and meets setup of chip enable to the first serial clock edge.
*/
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
module ldm_core #(
  parameter int DOTS = ldm_pkg::DOT_BITS
) (
  // System clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [ldm_pkg::ADR_BITS-1:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic wbAck,
  // Serial link from host
  input wire logic sclk,
  input wire logic ceN,
  input wire logic dataIn,
  input wire logic target_select,
  output logic dataOut,
  // Display control pins
  input wire logic blank_in,
  input wire logic oscSelect,
  input wire logic oscIn,
  output logic oscOut,
  output logic oscOe,
  // LED drive
  output logic [DOTS-1:0] ledOn,
  output logic [ldm_pkg::REFRESH_BITS-1:0] refreshCount
);

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisation into mclk

  ldm_pkg::ldm_pins_t pinsRaw, pins;

  assign pinsRaw = '{ceN: ceN, sclk: sclk, target: target_select,
                     blank: blank_in, oscSel: oscSelect, oscIn: oscIn};

  ldm_sync #(
    .WIDTH(ldm_pkg::PIN_BITS),
    .INIT(6'h20) // Idle levels: chip enable high, so no false frame edge
  ) u_sync (
    .clk(mclk),
    .rst(rst),
    .din(pinsRaw),
    .dout(pins)
  );

  //////////////////////////////////////////////////////////////////////////
  // Link domain: shift registers on the serial clock

  logic [DOTS-1:0] dotShift, next_dotShift;
  logic [ldm_pkg::CSR_BITS-1:0] ctrlShift, next_ctrlShift;
  logic target;
  logic [ldm_pkg::CW_BITS-1:0] cw0, cw1;

  // Target changes just after chip enable falls, before the first serial clock
  // edge, and cw1 only while chip enable is high, so both are steady at every shifting edge.
  always_comb
  begin
    next_dotShift = dotShift;
    next_ctrlShift = ctrlShift;
    if (!ceN) // [RULE2] [RULE19]
    begin
      if (target == ldm_pkg::TARGET_DOT)
        next_dotShift = {dotShift[DOTS-2:0], dataIn}; // [RULE10]
      else
        next_ctrlShift = {ctrlShift[ldm_pkg::CSR_BITS-2:0], dataIn}; // [RULE16]
    end
  end

  // No reset: dot data survives power-up and reset
  always_ff @(posedge sclk)
  begin
    dotShift <= next_dotShift; // [RULE14]
  end

  always_ff @(posedge sclk or posedge rst)
  begin
    if (rst)
      ctrlShift <= '0; // [RULE1]
    else
      ctrlShift <= next_ctrlShift;
  end

  // Simultaneous mode passes data in straight through, so this output
  // cannot be a flop without turning the mode back into serial.
  always_comb
  begin
    if (target == ldm_pkg::TARGET_CTRL && cw1[ldm_pkg::SIMUL_BIT])
      dataOut = dataIn; // [RULE3]
    else if (target == ldm_pkg::TARGET_CTRL)
      dataOut = ctrlShift[ldm_pkg::CW_SEL_BIT]; // [RULE3]
    else
      dataOut = dotShift[DOTS-1]; // [RULE3] [RULE12]
  end

  //////////////////////////////////////////////////////////////////////////
  // Frame tracking and copy to latch or control word

  logic prevCe, ceFall, ceRise, doCopy, next_target;
  ldm_pkg::ldm_copy_t state, next_state;
  logic [DOTS-1:0] dotLatch, next_dotLatch;
  logic [ldm_pkg::CW_BITS-1:0] next_cw0, next_cw1;

  assign ceFall = prevCe & ~pins.ceN;
  assign ceRise = ~prevCe & pins.ceN;

  always_comb
  begin
    next_state = state;
    doCopy = 1'b0;
    case (state)
      ldm_pkg::ST_IDLE:
      begin
        if (ceRise)
          next_state = ldm_pkg::ST_WAIT_LOW;
      end
      ldm_pkg::ST_WAIT_LOW:
      begin
        if (ceFall)
          next_state = ldm_pkg::ST_IDLE;
        else if (!pins.sclk)
        begin
          doCopy = 1'b1; // [RULE6]
          next_state = ldm_pkg::ST_IDLE;
        end
      end
      default:
        next_state = ldm_pkg::ST_IDLE;
    endcase
  end

  always_comb
  begin
    next_target = target;
    next_dotLatch = dotLatch;
    next_cw0 = cw0;
    next_cw1 = cw1;
    if (ceFall)
      next_target = pins.target; // [RULE4]
    if (doCopy && target == ldm_pkg::TARGET_DOT)
      next_dotLatch = dotShift; // [RULE6] [RULE11]
    else if (doCopy && ctrlShift[ldm_pkg::CW_SEL_BIT])
      next_cw1 = ctrlShift[ldm_pkg::CW_BITS-1:0]; // [RULE16]
    else if (doCopy)
      next_cw0 = ctrlShift[ldm_pkg::CW_BITS-1:0]; // [RULE16]
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state <= ldm_pkg::ST_IDLE;
      prevCe <= 1'b1;
      target <= ldm_pkg::TARGET_DOT;
      cw0 <= ldm_pkg::CW_RESET; // [RULE1] [RULE13]
      cw1 <= ldm_pkg::CW_RESET; // [RULE1]
    end
    else
    begin
      state <= next_state;
      prevCe <= pins.ceN;
      target <= next_target;
      cw0 <= next_cw0;
      cw1 <= next_cw1;
    end
  end

  always_ff @(posedge mclk)
  begin
    dotLatch <= next_dotLatch; // [RULE14]
  end

  //////////////////////////////////////////////////////////////////////////
  // Display clock, refresh and LED drive

  logic awake, intOsc, next_intOsc, prevOscIn, dispTick, next_oscOe;
  logic [ldm_pkg::OSC_CNT_BITS-1:0] oscCnt, next_oscCnt;
  logic [2:0] preCnt, next_preCnt;
  logic [DOTS-1:0] next_ledOn;
  logic [ldm_pkg::REFRESH_BITS-1:0] next_refreshCount;

  assign awake = cw0[ldm_pkg::SLEEP_BIT];

  always_comb
  begin
    next_oscCnt = oscCnt;
    next_intOsc = intOsc;
    next_preCnt = preCnt;
    dispTick = 1'b0;
    if (pins.oscSel) // [RULE7]
    begin
      if (awake) // [RULE17]
      begin
        if (oscCnt == ldm_pkg::OSC_CNT_BITS'(ldm_pkg::INT_OSC_HALF - 1))
        begin
          next_oscCnt = '0;
          next_intOsc = ~intOsc;
          dispTick = ~intOsc;
        end
        else
          next_oscCnt = oscCnt + 1'b1;
      end
    end
    else if (pins.oscIn && !prevOscIn) // [RULE7] [RULE8]
    begin
      if (!cw1[ldm_pkg::PRESCALE_BIT])
        dispTick = 1'b1;
      else
      begin
        next_preCnt = preCnt + 1'b1;
        dispTick = (preCnt == 3'(ldm_pkg::PRESCALE_DIV - 1));
      end
    end
  end

  always_comb
  begin
    next_oscOe = pins.oscSel; // [RULE8]
    next_refreshCount = refreshCount;
    if (awake && dispTick)
      next_refreshCount = refreshCount + 1'b1;
    if (awake && !pins.blank)
      next_ledOn = dotLatch; // [RULE11]
    else
      next_ledOn = '0; // [RULE9] [RULE13] [RULE17]
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      oscCnt <= '0;
      intOsc <= 1'b0;
      prevOscIn <= 1'b0;
      preCnt <= '0;
      oscOut <= 1'b0;
      oscOe <= 1'b0;
      ledOn <= '0;
      refreshCount <= '0;
    end
    else
    begin
      oscCnt <= next_oscCnt;
      intOsc <= next_intOsc;
      prevOscIn <= pins.oscIn;
      preCnt <= next_preCnt;
      oscOut <= next_intOsc & pins.oscSel; // [RULE8]
      oscOe <= next_oscOe;
      ledOn <= next_ledOn;
      refreshCount <= next_refreshCount;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Wishbone slave

  logic [ldm_pkg::IDX_BITS-1:0] dotIndex, next_dotIndex;
  logic [31:0] next_wbDatO, statusWord;
  logic next_wbAck, wbReq;
  logic [DOTS-1:0] dotShifted;

  assign wbReq = wbCyc & wbStb & ~wbAck;
  assign dotShifted = dotLatch >> {dotIndex, 5'h00};

  always_comb
  begin
    statusWord = '0;
    statusWord[ldm_pkg::ST_CW0_LSB +: ldm_pkg::CW_BITS] = cw0;
    statusWord[ldm_pkg::ST_CW1_LSB +: ldm_pkg::CW_BITS] = cw1;
    statusWord[ldm_pkg::ST_TARGET_BIT] = target;
    statusWord[ldm_pkg::ST_OSCSEL_BIT] = pins.oscSel;
    statusWord[ldm_pkg::ST_BLANK_BIT] = pins.blank;
    statusWord[ldm_pkg::ST_AWAKE_BIT] = awake;
  end

  always_comb
  begin
    next_wbAck = wbReq;
    next_wbDatO = '0;
    next_dotIndex = dotIndex;
    if (wbReq && wbWe && wbSel[0] && wbAdr == ldm_pkg::ADR_DOT_INDEX)
      next_dotIndex = wbDatI[ldm_pkg::IDX_BITS-1:0];
    if (wbReq && !wbWe)
    begin
      case (wbAdr)
        ldm_pkg::ADR_STATUS:
          next_wbDatO = statusWord;
        ldm_pkg::ADR_DOT_INDEX:
          next_wbDatO = {29'h0000000, dotIndex};
        ldm_pkg::ADR_DOT_DATA:
        begin
          if (dotIndex < ldm_pkg::IDX_BITS'(ldm_pkg::DOT_WORDS))
            next_wbDatO = dotShifted[31:0];
        end
        default:
          next_wbDatO = '0;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      wbAck <= 1'b0;
      wbDatO <= '0;
      dotIndex <= '0;
    end
    else
    begin
      wbAck <= next_wbAck;
      wbDatO <= next_wbDatO;
      dotIndex <= next_dotIndex;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence s_frame_end;
    ceRise ##1 (pins.ceN && !pins.sclk);
  endsequence
  sequence s_ctrl_copy;
    doCopy && target == ldm_pkg::TARGET_CTRL;
  endsequence
  a_bus_ack_once: assert property (wbAck |=> !wbAck)
    else $error("ack held longer than one cycle");
  a_bus_ack_next: assert property (wbReq |=> wbAck)
    else $error("request not acknowledged in next cycle");
  a_target_catch: assert property ( // [RULE4]
    ceFall |=> target == $past(pins.target))
    else $error("target select not caught at enable fall");
  a_frame_copy_done: assert property ( // [RULE6]
    s_frame_end |-> doCopy ##1 state == ldm_pkg::ST_IDLE)
    else $error("copy not done after frame end with clock low");
  a_word_keep_other: assert property ( // [RULE16]
    s_ctrl_copy and ctrlShift[ldm_pkg::CW_SEL_BIT]
    |=> cw0 == $past(cw0) && cw1 == $past(ctrlShift[6:0]))
    else $error("wrong control word updated");
  a_ctrl_hold_low: assert property ( // [RULE19]
    !pins.ceN ##1 !pins.ceN |-> $stable(cw0) && $stable(cw1))
    else $error("control word changed during a frame");
  a_blank_dark: assert property ( // [RULE9]
    pins.blank |=> ledOn == '0)
    else $error("LEDs lit while blanked");
  a_sleep_dark: assert property ( // [RULE17]
    !awake |=> ledOn == '0 && $stable(refreshCount))
    else $error("LEDs or refresh active in sleep");
  a_osc_drive: assert property ( // [RULE8]
    pins.oscSel != $past(pins.oscSel) |=> oscOe == $past(pins.oscSel))
    else $error("oscillator pin direction wrong");
  a_ext_osc_quiet: assert property ( // [RULE7]
    !pins.oscSel [*2] |-> !oscOut)
    else $error("oscillator driven while external source selected");
endmodule

// *** dv/ldm_host_model.sv ***
/*
  Host model of the serial write link: dot and control frames.
  Assumes the loader shifts on sclk rise and copies once ceN is high
  with sclk low.
*/
`timescale 1ns/10ps
module ldm_host_model (
  // Serial link
  output logic sclk,
  output logic ceN,
  output logic dataIn,
  output logic target_select
);
  initial
  begin
    sclk = 1'b0;
    ceN = 1'b1;
    dataIn = 1'b1;
    target_select = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock idles low between frames; released lines show the inverse
  task automatic frame(input logic tgt, input int n,
    input logic [ldm_pkg::DOT_BITS-1:0] b);
    target_select = tgt;
    #12 ceN = 1'b0;
    #48;
    for (int i = n - 1; i >= 0; i--)
    begin
      dataIn = b[i];
      #12 sclk = 1'b1;
      #24 sclk = 1'b0;
      #12;
    end
    dataIn = ~dataIn;
    #12 ceN = 1'b1;
    #12 target_select = ~tgt;
    #40;
  endtask

  task automatic send_dot(input logic [ldm_pkg::DOT_BITS-1:0] b);
    frame(ldm_pkg::TARGET_DOT, ldm_pkg::DOT_BITS, b);
  endtask

  task automatic send_ctrl(input logic [ldm_pkg::CSR_BITS-1:0] b);
    frame(ldm_pkg::TARGET_CTRL, ldm_pkg::CSR_BITS, 160'(b));
  endtask

  // Serial clock pulses while chip enable stays high
  task automatic stray(input int n);
    repeat (n)
    begin
      #24 sclk = 1'b1;
      #24 sclk = 1'b0;
    end
  endtask
endmodule

// *** dv/tb.sv ***
/*
  Self-checking bench of the serial dot matrix loader.
  Assumes the host model drives the link while the bench, as Wishbone
  master, reads status and dot latch words.
*/
`timescale 1ns/10ps
module tb;
  typedef struct packed {
    logic [7:0] cmd;
    logic [6:0] c0;
    logic [6:0] c1;
  } ldm_row_t;
  localparam ldm_row_t ROWS [6] = '{
    '{8'h0f, 7'h0f, 7'h00}, '{8'h4f, 7'h4f, 7'h00},
    '{8'h82, 7'h4f, 7'h02}, '{8'h81, 7'h4f, 7'h01},
    '{8'h80, 7'h4f, 7'h00}, '{8'h7a, 7'h7a, 7'h00}};
  localparam logic [159:0] PAT = {32'h8000_0001, 32'h1234_5678,
    32'h0f0f_00ff, 32'ha5a5_5a5a, 32'h0000_0003};
  localparam int LIMIT = 20000;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [ldm_pkg::ADR_BITS-1:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'h1;
  logic [31:0] wbDatI = 32'h0;
  logic [31:0] wbDatO;
  logic wbAck;
  logic sclk, ceN, dataIn, target_select, dataOut, oscOut, oscOe;
  logic blank_in = 1'b0;
  logic oscSelect = 1'b0;
  logic oscIn = 1'b0;
  logic [159:0] ledOn;
  logic [ldm_pkg::REFRESH_BITS-1:0] refreshCount, rc;
  logic [31:0] q;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  int k;

  always #2 mclk = ~mclk;

  ldm_host_model host (.sclk(sclk), .ceN(ceN), .dataIn(dataIn),
    .target_select(target_select));

  ldm_core DUT (.mclk(mclk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI),
    .wbDatO(wbDatO), .wbAck(wbAck), .sclk(sclk), .ceN(ceN),
    .dataIn(dataIn), .target_select(target_select), .dataOut(dataOut),
    .blank_in(blank_in), .oscSelect(oscSelect), .oscIn(oscIn),
    .oscOut(oscOut), .oscOe(oscOe), .ledOn(ledOn),
    .refreshCount(refreshCount));

  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // External display clock pulses on the oscillator pin
  task automatic ext_ticks(input int n);
    repeat (n)
    begin
      oscIn <= 1'b1;
      tick(8);
      oscIn <= 1'b0;
      tick(8);
    end
  endtask

  task automatic cmp(input logic [159:0] g, input logic [159:0] e);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  // Classic cycle: held until ack is sampled, then released
  task automatic wb(input logic we, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge mclk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatI <= d;
    do
    begin
      @(posedge mclk);
    end
    while (wbAck !== 1'b1);
    q = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
    input logic [31:0] m = 32'hffff_ffff);
    wb(1'b0, a, 32'h0);
    cmp(160'(q & m), 160'(e & m));
  endtask

  task automatic dots(input logic [159:0] e);
    for (int i = 0; i < ldm_pkg::DOT_WORDS; i++)
    begin
      wb(1'b1, ldm_pkg::ADR_DOT_INDEX, 32'(i));
      rd(ldm_pkg::ADR_DOT_DATA, e[32*i +: 32]);
    end
  endtask

  function automatic logic [31:0] st(input logic [6:0] c0, c1,
    input logic t);
    st = 32'(c0) | (32'(c1) << ldm_pkg::ST_CW1_LSB)
      | (32'(t) << ldm_pkg::ST_TARGET_BIT)
      | (32'(oscSelect) << ldm_pkg::ST_OSCSEL_BIT)
      | (32'(blank_in) << ldm_pkg::ST_BLANK_BIT)
      | (32'(c0[ldm_pkg::SLEEP_BIT]) << ldm_pkg::ST_AWAKE_BIT);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial
  begin
    tick(12);
    rst <= 1'b0;
    tick(4);
    rd(ldm_pkg::ADR_STATUS, 32'h0, 32'hfffe_ffff);
    cmp(ledOn, '0);
    rd(8'h0c, 32'h0);
    host.send_dot('0);
    tick(8);
    dots('0);
    host.send_dot(PAT);
    tick(8);
    dots(PAT);
    cmp(ledOn, '0);
    cmp(160'(dataOut), 160'(PAT[159]));
    foreach (ROWS[i])
    begin
      host.send_ctrl(ROWS[i].cmd);
      tick(8);
      rd(ldm_pkg::ADR_STATUS, st(ROWS[i].c0, ROWS[i].c1, 1'b1));
      cmp(ledOn, ROWS[i].c0[ldm_pkg::SLEEP_BIT] ? PAT : '0);
      cmp(160'(dataOut),
        160'(ROWS[i].c1[0] ? dataIn : ROWS[i].cmd[7]));
    end
    // Blank pulse as a brightness control
    blank_in <= 1'b1;
    tick(4);
    cmp(ledOn, '0);
    blank_in <= 1'b0;
    tick(4);
    cmp(ledOn, PAT);
    host.stray(6);
    tick(8);
    dots(PAT);
    rd(ldm_pkg::ADR_STATUS, st(7'h7a, 7'h00, 1'b1));
    host.send_dot(~PAT);
    tick(8);
    rd(ldm_pkg::ADR_STATUS, st(7'h7a, 7'h00, 1'b0));
    cmp(ledOn, ~PAT);
    // Internal then external display clock
    oscSelect <= 1'b1;
    tick(4);
    cmp(160'(oscOe), 160'(1'b1));
    for (k = 0; k < 1300 && oscOut !== 1'b1; k++)
      @(posedge mclk);
    cmp(160'(oscOut), 160'(1'b1));
    oscSelect <= 1'b0;
    tick(4);
    cmp(160'(oscOe), 160'(1'b0));
    rc = refreshCount;
    ext_ticks(4);
    cmp(160'(refreshCount), 160'(rc + 9'h4));
    // Prescaler on: eight external edges make one display tick
    host.send_ctrl(8'h82);
    tick(8);
    rc = refreshCount;
    ext_ticks(7);
    cmp(160'(refreshCount), 160'(rc));
    ext_ticks(1);
    cmp(160'(refreshCount), 160'(rc + 9'h1));
    rst <= 1'b1;
    tick(3);
    rst <= 1'b0;
    tick(4);
    rd(ldm_pkg::ADR_STATUS, 32'h0, 32'hfffe_ffff);
    cmp(ledOn, '0);
    dots(~PAT);
    tally_and_finish();
  end
endmodule
